// ===== core/rfe_tx_encoder.sv
`default_nettype none
module rfe_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } rfe_fifo_s;
  rfe_fifo_s st_ff;
  rfe_fifo_s nxt_st;
  logic      push;
  logic      pop;

  assign in_ready  = (st_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_ff.cnt != '0);
  assign out_data  = st_ff.mem[st_ff.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    nxt_st = st_ff;
    if (push)
    begin
      nxt_st.mem[st_ff.wp] = in_data;
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (pop)
      nxt_st.rp = st_ff.rp + 1'b1;
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
endmodule

module rfe_tx_encoder (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // register port
  input  wire rfe_pkg::rfe_bus_s bus,
  output logic [7:0]             rd_data,
  // asynchronous sources for the test pin
  input  wire logic              rx_envelope,
  input  wire logic              rx_active,
  input  wire logic              rx_bit,
  input  wire logic              generic_secure_if_signal,
  // transmit side
  output logic                   tx_envelope,
  output logic                   tx_active,
  output logic                   tx_fifo_ready,
  // pins
  output logic                   test_signal_pin_out,
  output logic                   test_signal_pin_oe,
  output logic                   io_fast_switching
);
  typedef struct packed {
    rfe_pkg::rfe_test_out_s test_out;
    rfe_pkg::rfe_framing_s  framing;
    rfe_pkg::rfe_coding_s   coding;
    logic                   parity_en;
    logic                   start_req;
    rfe_pkg::rfe_fsm_e      fsm;
    rfe_pkg::rfe_phase_e    phase;
    logic [7:0]             data;
    logic [2:0]             bit_idx;
    logic                   last;
    logic [7:0]             sym;
    logic [3:0]             sym_cnt;
    logic [8:0]             slot;
    logic [2:0]             qtr;
    logic [11:0]            qcnt;
    logic [6:0]             sc_cnt;
    logic                   sc_ph;
    logic [3:0]             sync1;
    logic [3:0]             sync2;
    logic                   env;
    logic                   pin_out;
    logic                   pin_oe;
    logic [7:0]             rd_data;
    logic                   fifo_ready;
    logic                   busy;
  } rfe_state_s;

  rfe_state_s st_ff;
  rfe_state_s nxt_st;
  logic       f_in_valid;
  logic       f_in_ready;
  logic       f_out_valid;
  logic [7:0] f_out_data;
  logic       f_pop;
  logic       cur_bit;
  logic [7:0] sym_val;
  logic [7:0] sym_next;
  logic [2:0] qtr_max;
  logic [11:0] qlen;
  logic [6:0] sc_half;

  function automatic logic [3:0] sym_bits(input logic [3:0] code);
    if (code == rfe_pkg::CODE_1OF4)
      return rfe_pkg::BITS_1OF4;
    if (code >= rfe_pkg::CODE_256 && code <= rfe_pkg::CODE_256_LAST)
      return rfe_pkg::BITS_BYTE;
    return 4'h1;
  endfunction

  function automatic logic [8:0] slot_max(input logic [3:0] code);
    if (code == rfe_pkg::CODE_1OF4)
      return rfe_pkg::SLOT_1OF4;
    if (code >= rfe_pkg::CODE_256 && code <= rfe_pkg::CODE_256_LAST)
      return rfe_pkg::SLOT_LAST;
    return 9'h000;
  endfunction

  // first bit of a symbol ends up as its lowest bit
  function automatic logic [7:0] sym_value(input logic [7:0] s,
                                           input logic [3:0] code);
    return s >> (rfe_pkg::BITS_BYTE - sym_bits(code));
  endfunction

  function automatic logic envelope(input rfe_state_s s,
                                    input logic [7:0] v);
    logic [3:0] c;
    c = s.coding.tx_code_sel;
    case (c)
      // collider halves, modulated half on subcarrier
      rfe_pkg::CODE_COLLIDER:
        return ((s.qtr[1] ? !v[0] : v[0]) && s.sc_ph);
      // pulse in quarter given by code
      4'h4, 4'h5, 4'h6, rfe_pkg::CODE_RZ4:
        return v[0] && (s.qtr[1:0] == 2'(c - rfe_pkg::CODE_RZ1));
      // pulse in slot selected by symbol
      rfe_pkg::CODE_1OF4, rfe_pkg::CODE_256:
        return (s.slot == {1'b0, v}) && (s.qtr == '0);
      rfe_pkg::CODE_256_NOZ:
        return (v != '0) && (s.slot == {1'b0, v}) && (s.qtr == '0);
      // zero value moves to last slot
      rfe_pkg::CODE_256_LAST:
        return (s.slot == ((v == '0) ? rfe_pkg::SLOT_LAST : {1'b0, v}))
               && (s.qtr == '0);
      // pause closes each symbol, long for one
      rfe_pkg::CODE_IVL:
        return s.qtr == (v[0] ? rfe_pkg::QTR_IVL_LONG
                              : rfe_pkg::QTR_NORM);
      // plain level, reserved codes fall here
      default:
        return v[0];
    endcase
  endfunction

  rfe_fifo #(
    .WIDTH(rfe_pkg::FIFO_WIDTH),
    .DEPTH(rfe_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_valid  (f_in_valid),
    .in_data   (bus.wdata),
    .in_ready  (f_in_ready),
    .out_valid (f_out_valid),
    .out_data  (f_out_data),
    .out_ready (f_pop)
  );

  // bytes written while full are dropped; software polls the ready flag
  assign f_in_valid = bus.wr && (bus.addr == rfe_pkg::ADDR_TX_DATA);

  always_comb
  begin
    nxt_st = st_ff;
    f_pop = 1'b0;
    sym_val = sym_value(st_ff.sym, st_ff.coding.tx_code_sel);
    // quarter length doubles per step below top rate, down to RATE_MIN; slower selects are clamped to it
    qlen = 12'(rfe_pkg::QTR_CYC) << (rfe_pkg::RATE_MAX -
           ((st_ff.coding.tx_bit_rate_sel < rfe_pkg::RATE_MIN)
            ? rfe_pkg::RATE_MIN : st_ff.coding.tx_bit_rate_sel));
    qtr_max = ((st_ff.coding.tx_code_sel == rfe_pkg::CODE_IVL) && sym_val[0])
              ? rfe_pkg::QTR_IVL_LONG : rfe_pkg::QTR_NORM;
    sc_half = st_ff.coding.tx_subcarrier_sel ? 7'(rfe_pkg::SC_HI_HALF)
                                             : 7'(rfe_pkg::SC_LO_HALF);
    cur_bit = 1'b0;
    case (st_ff.phase)
      rfe_pkg::PH_START:  cur_bit = st_ff.framing.tx_start_level;
      rfe_pkg::PH_DATA:   cur_bit = st_ff.framing.tx_high_bit_first
                                    ? st_ff.data[3'h7 - st_ff.bit_idx]
                                    : st_ff.data[st_ff.bit_idx];
      rfe_pkg::PH_PARITY: cur_bit = ^st_ff.data
                                    ^ st_ff.framing.tx_parity_odd_sel;
      default:            cur_bit = st_ff.framing.tx_stop_level;
    endcase
    sym_next = {cur_bit, st_ff.sym[7:1]};

    nxt_st.sync1 = {rx_bit, rx_active, rx_envelope,
                    generic_secure_if_signal};
    nxt_st.sync2 = st_ff.sync1;
    if (st_ff.sc_cnt >= sc_half - 7'h01)
    begin
      nxt_st.sc_cnt = '0;
      nxt_st.sc_ph = !st_ff.sc_ph;
    end
    else
      nxt_st.sc_cnt = st_ff.sc_cnt + 7'h01;

    if (bus.wr)
    begin
      case (bus.addr)
        // pad speed stored with source select
        rfe_pkg::ADDR_TEST_OUT:
          nxt_st.test_out = bus.wdata & rfe_pkg::MASK_TEST_OUT;
        rfe_pkg::ADDR_FRAMING:
          nxt_st.framing = bus.wdata & rfe_pkg::MASK_FRAMING;
        rfe_pkg::ADDR_CODING:
          nxt_st.coding = bus.wdata;
        rfe_pkg::ADDR_TX_CTRL:
        begin
          nxt_st.parity_en = bus.wdata[rfe_pkg::CTRL_PAR_EN];
          if (bus.wdata[rfe_pkg::CTRL_START])
            nxt_st.start_req = 1'b1;
        end
        default: ;
      endcase
    end

    case (st_ff.fsm)
      rfe_pkg::FSM_IDLE:
      begin
        if (st_ff.start_req && f_out_valid)
        begin
          f_pop = 1'b1;
          // start request taken; a new one in this cycle still waits
          nxt_st.start_req = nxt_st.start_req && bus.wr &&
                             (bus.addr == rfe_pkg::ADDR_TX_CTRL) &&
                             bus.wdata[rfe_pkg::CTRL_START];
          nxt_st.data = f_out_data;
          nxt_st.bit_idx = '0;
          nxt_st.last = 1'b0;
          nxt_st.sym_cnt = '0;
          nxt_st.fsm = rfe_pkg::FSM_GATHER;
          nxt_st.phase = st_ff.framing.tx_start_insert
                         ? rfe_pkg::PH_START : rfe_pkg::PH_DATA;
        end
      end
      rfe_pkg::FSM_GATHER:
      begin
        nxt_st.sym = sym_next;
        nxt_st.sym_cnt = st_ff.sym_cnt + 4'h1;
        case (st_ff.phase)
          rfe_pkg::PH_START: nxt_st.phase = rfe_pkg::PH_DATA;
          rfe_pkg::PH_DATA:
          begin
            nxt_st.bit_idx = st_ff.bit_idx + 3'h1;
            if (st_ff.bit_idx == 3'h7)
            begin
              if (st_ff.parity_en)
                nxt_st.phase = rfe_pkg::PH_PARITY;
              else if (f_out_valid)
              begin
                f_pop = 1'b1;
                nxt_st.data = f_out_data;
              end
              else
                nxt_st.phase = rfe_pkg::PH_STOP;
            end
          end
          rfe_pkg::PH_PARITY:
          begin
            nxt_st.phase = f_out_valid ? rfe_pkg::PH_DATA
                                       : rfe_pkg::PH_STOP;
            f_pop = f_out_valid;
            if (f_out_valid)
              nxt_st.data = f_out_data;
          end
          default: nxt_st.last = 1'b1;
        endcase
        if (st_ff.sym_cnt + 4'h1 == sym_bits(st_ff.coding.tx_code_sel) ||
            st_ff.phase == rfe_pkg::PH_STOP)
        begin
          nxt_st.sym_cnt = '0;
          nxt_st.slot = '0;
          nxt_st.qtr = '0;
          nxt_st.qcnt = '0;
          nxt_st.fsm = rfe_pkg::FSM_PLAY;
        end
      end
      rfe_pkg::FSM_PLAY:
      begin
        nxt_st.qcnt = st_ff.qcnt + 12'h001;
        if (st_ff.qcnt >= qlen - 12'h001)
        begin
          nxt_st.qcnt = '0;
          nxt_st.qtr = st_ff.qtr + 3'h1;
          if (st_ff.qtr == qtr_max)
          begin
            nxt_st.qtr = '0;
            nxt_st.slot = st_ff.slot + 9'h001;
            if (st_ff.slot == slot_max(st_ff.coding.tx_code_sel))
              nxt_st.fsm = st_ff.last ? rfe_pkg::FSM_IDLE
                                      : rfe_pkg::FSM_GATHER;
          end
        end
      end
      default: nxt_st.fsm = rfe_pkg::FSM_IDLE;
    endcase
    // busy flag registered so tx_active leaves a flop
    nxt_st.busy = (nxt_st.fsm != rfe_pkg::FSM_IDLE);

    nxt_st.env = (st_ff.fsm == rfe_pkg::FSM_PLAY) &&
                 envelope(st_ff, sym_val);

    nxt_st.pin_oe = 1'b1;
    case (st_ff.test_out.test_pin_source_sel)
      rfe_pkg::SEL_LOW:    nxt_st.pin_out = 1'b0;
      rfe_pkg::SEL_HIGH:   nxt_st.pin_out = 1'b1;
      rfe_pkg::SEL_TX_ENV: nxt_st.pin_out = st_ff.env;
      rfe_pkg::SEL_TX_ACT: nxt_st.pin_out = st_ff.fsm != rfe_pkg::FSM_IDLE;
      rfe_pkg::SEL_SECURE: nxt_st.pin_out = st_ff.sync2[rfe_pkg::LN_SEC];
      rfe_pkg::SEL_RX_ENV: nxt_st.pin_out = st_ff.sync2[rfe_pkg::LN_RXE];
      rfe_pkg::SEL_RX_ACT: nxt_st.pin_out = st_ff.sync2[rfe_pkg::LN_RXA];
      rfe_pkg::SEL_RX_BIT: nxt_st.pin_out = st_ff.sync2[rfe_pkg::LN_RXB];
      default:
      begin
        nxt_st.pin_out = 1'b0;
        nxt_st.pin_oe = 1'b0;
      end
    endcase

    nxt_st.fifo_ready = f_in_ready;
    nxt_st.rd_data = rfe_pkg::RSV_ZERO;
    if (bus.rd)
    begin
      case (bus.addr)
        rfe_pkg::ADDR_TEST_OUT: nxt_st.rd_data = st_ff.test_out;
        rfe_pkg::ADDR_FRAMING:  nxt_st.rd_data = st_ff.framing;
        rfe_pkg::ADDR_CODING:   nxt_st.rd_data = st_ff.coding;
        rfe_pkg::ADDR_TX_DATA:
          nxt_st.rd_data = {5'h00, f_out_valid, f_in_ready,
                            st_ff.fsm != rfe_pkg::FSM_IDLE};
        rfe_pkg::ADDR_TX_CTRL:
          nxt_st.rd_data = {6'h00, st_ff.parity_en, st_ff.start_req};
        default: nxt_st.rd_data = rfe_pkg::RSV_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      st_ff <= '0;
      st_ff.fsm <= rfe_pkg::FSM_IDLE;
      st_ff.phase <= rfe_pkg::PH_START;
    end
    else
      st_ff <= nxt_st;
  end

  assign rd_data             = st_ff.rd_data;
  assign tx_envelope         = st_ff.env;
  assign tx_active           = st_ff.busy;
  assign tx_fifo_ready       = st_ff.fifo_ready;
  assign test_signal_pin_out = st_ff.pin_out;
  assign test_signal_pin_oe  = st_ff.pin_oe;
  assign io_fast_switching   = st_ff.test_out.io_fast_switching;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_launch;
    st_ff.fsm == rfe_pkg::FSM_IDLE && st_ff.start_req && f_out_valid;
  endsequence
  sequence s_gather(rfe_pkg::rfe_phase_e ph);
    st_ff.fsm == rfe_pkg::FSM_GATHER && st_ff.phase == ph;
  endsequence

  AST_PIN_HIZ: assert property (
    st_ff.test_out.test_pin_source_sel <= rfe_pkg::SEL_HIZ1
    |=> !test_signal_pin_oe)
    else $error("test pin driven while select floats it");
  AST_PIN_LOW: assert property (
    st_ff.test_out.test_pin_source_sel == rfe_pkg::SEL_LOW
    |=> test_signal_pin_oe && !test_signal_pin_out)
    else $error("test pin not driven low");
  AST_PIN_TXENV: assert property (
    st_ff.test_out.test_pin_source_sel == rfe_pkg::SEL_TX_ENV
    |=> test_signal_pin_out == $past(tx_envelope))
    else $error("test pin does not follow tx envelope");
  AST_PIN_RXBIT: assert property (
    st_ff.test_out.test_pin_source_sel == rfe_pkg::SEL_RX_BIT
    |=> test_signal_pin_out == $past(st_ff.sync2[rfe_pkg::LN_RXB]))
    else $error("test pin does not follow rx bit");
  AST_PAD_SPEED: assert property (
    bus.wr && bus.addr == rfe_pkg::ADDR_TEST_OUT
    |=> io_fast_switching == $past(bus.wdata[7]))
    else $error("pad speed output not updated");
  AST_BIT_ORDER: assert property (
    s_gather(rfe_pkg::PH_DATA) ##0 st_ff.bit_idx == 3'h0
    |=> st_ff.sym[7] == $past(st_ff.framing.tx_high_bit_first
                              ? st_ff.data[7] : st_ff.data[0]))
    else $error("first data bit in wrong order");
  AST_PARITY: assert property (
    s_gather(rfe_pkg::PH_PARITY)
    |=> st_ff.sym[7] == $past(^st_ff.data ^ st_ff.framing.tx_parity_odd_sel))
    else $error("parity bit wrong");
  AST_STOP_LVL: assert property (
    s_gather(rfe_pkg::PH_STOP)
    |=> st_ff.sym[7] == $past(st_ff.framing.tx_stop_level)
        && st_ff.fsm == rfe_pkg::FSM_PLAY)
    else $error("stop bit level wrong");
  AST_START_INS: assert property (
    s_launch |=> st_ff.phase == ($past(st_ff.framing.tx_start_insert)
                 ? rfe_pkg::PH_START : rfe_pkg::PH_DATA))
    else $error("start bit insertion wrong");
  AST_NOZ_ZERO: assert property (
    st_ff.fsm == rfe_pkg::FSM_PLAY && sym_val == '0 &&
    st_ff.coding.tx_code_sel == rfe_pkg::CODE_256_NOZ |=> !tx_envelope)
    else $error("zero value modulated");
endmodule
`default_nettype wire

// ===== core/rfe_pkg.sv
`default_nettype none
package rfe_pkg;
  // register map, byte-wide registers at their own addresses
  localparam logic [7:0] ADDR_TEST_OUT = 8'h47;
  localparam logic [7:0] ADDR_FRAMING  = 8'h48;
  localparam logic [7:0] ADDR_CODING   = 8'h4A;
  localparam logic [7:0] ADDR_TX_DATA  = 8'h4C;
  localparam logic [7:0] ADDR_TX_CTRL  = 8'h4D;
  localparam logic [7:0] RSV_ZERO      = 8'h00;
  localparam logic [7:0] MASK_TEST_OUT = 8'h8F;
  localparam logic [7:0] MASK_FRAMING  = 8'hAB;
  localparam int CTRL_START  = 0;
  localparam int CTRL_PAR_EN = 1;
  // test pin sources
  localparam logic [3:0] SEL_HIZ1   = 4'h1;
  localparam logic [3:0] SEL_LOW    = 4'h2;
  localparam logic [3:0] SEL_HIGH   = 4'h3;
  localparam logic [3:0] SEL_TX_ENV = 4'h4;
  localparam logic [3:0] SEL_TX_ACT = 4'h5;
  localparam logic [3:0] SEL_SECURE = 4'h6;
  localparam logic [3:0] SEL_RX_ENV = 4'h7;
  localparam logic [3:0] SEL_RX_ACT = 4'h8;
  localparam logic [3:0] SEL_RX_BIT = 4'h9;
  // synchroniser lanes
  localparam int LN_SEC = 0;
  localparam int LN_RXE = 1;
  localparam int LN_RXA = 2;
  localparam int LN_RXB = 3;
  // data codes
  localparam logic [3:0] CODE_NONE     = 4'h0;
  localparam logic [3:0] CODE_COLLIDER = 4'h1;
  localparam logic [3:0] CODE_RZ1      = 4'h4;
  localparam logic [3:0] CODE_RZ4      = 4'h7;
  localparam logic [3:0] CODE_1OF4     = 4'h8;
  localparam logic [3:0] CODE_256      = 4'h9;
  localparam logic [3:0] CODE_256_NOZ  = 4'hA;
  localparam logic [3:0] CODE_256_LAST = 4'hB;
  localparam logic [3:0] CODE_IVL      = 4'hC;
  localparam logic [8:0] SLOT_LAST     = 9'h0FF;
  localparam logic [8:0] SLOT_1OF4     = 9'h003;
  localparam logic [3:0] BITS_1OF4     = 4'h2;
  localparam logic [3:0] BITS_BYTE     = 4'h8;
  localparam logic [2:0] QTR_NORM      = 3'h3;
  localparam logic [2:0] QTR_IVL_LONG  = 3'h7;
  localparam logic [2:0] RATE_MIN      = 3'h2;
  localparam logic [2:0] RATE_MAX      = 3'h7;
  // timing, 848 kHz is the fastest bit rate and subcarrier
  localparam int CLK_HZ     = 100_000_000;
  localparam int TOP_HZ     = 848_000;
  localparam int SC_LOW_HZ  = 424_000;
  localparam int QTR_CYC    = CLK_HZ / TOP_HZ / 4;
  localparam int SC_HI_HALF = CLK_HZ / TOP_HZ / 2;
  localparam int SC_LO_HALF = CLK_HZ / SC_LOW_HZ / 2;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 8;

  typedef struct packed {
    logic       io_fast_switching;
    logic [2:0] rsv;
    logic [3:0] test_pin_source_sel;
  } rfe_test_out_s;
  typedef struct packed {
    logic tx_high_bit_first;
    logic rsv6;
    logic tx_parity_odd_sel;
    logic rsv4;
    logic tx_stop_level;
    logic rsv2;
    logic tx_start_level;
    logic tx_start_insert;
  } rfe_framing_s;
  typedef struct packed {
    logic [3:0] tx_code_sel;
    logic       tx_subcarrier_sel;
    logic [2:0] tx_bit_rate_sel;
  } rfe_coding_s;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rfe_bus_s;
  typedef enum logic [2:0] {
    FSM_IDLE   = 3'b001,
    FSM_GATHER = 3'b010,
    FSM_PLAY   = 3'b100
  } rfe_fsm_e;
  typedef enum logic [3:0] {
    PH_START  = 4'b0001,
    PH_DATA   = 4'b0010,
    PH_PARITY = 4'b0100,
    PH_STOP   = 4'b1000
  } rfe_phase_e;
endpackage
`default_nettype wire

// ===== tb/rfe_card_model.sv
`default_nettype none
module rfe_card_model (
  // clock
  input  wire logic       clock,
  // reader side
  input  wire logic       tx_envelope,
  input  wire logic       tx_active,
  // answer levels chosen by the bench
  input  wire logic [3:0] resp,
  output logic      [3:0] rx_lines,
  // what the card heard in the last frame
  output int              pulses,
  output int              first_at
);
  timeunit 1ns;
  timeprecision 1ns;
  logic env_q = 1'b0;
  logic act_q = 1'b0;
  int   age   = 0;
  // levels only, the card never floats these lines
  assign rx_lines = resp;
  always @(posedge clock)
  begin
    env_q <= tx_envelope;
    act_q <= tx_active;
    age   <= age + 1;
    if (tx_active && !act_q)
    begin
      pulses   <= 0;
      age      <= 1;
      first_at <= -1;
    end
    else if (tx_envelope && !env_q)
    begin
      pulses <= pulses + 1;
      if (first_at < 0)
        first_at <= age;
    end
  end
endmodule
`default_nettype wire

// ===== tb/rfe_tx_encoder_test.sv
`default_nettype none
module rfe_tx_encoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clock     = 1'b0;
  logic              sys_rst   = 1'b1;
  rfe_pkg::rfe_bus_s bus       = '0;
  logic [3:0]        resp      = 4'h0;
  logic [7:0]        rd_data;
  logic [3:0]        rxl;
  logic              env;
  logic              act;
  logic              fifo_rdy;
  logic              pin_out;
  logic              pin_oe;
  logic              io_fast;
  int                pulses;
  int                first_at;
  int                d0;
  int                cyc       = 0;
  int                error_cnt = 0;
  int                checked   = 0;
  logic [7:0]        fr_t[4]   = '{8'h2B, 8'h01, 8'h02, 8'h08};
  logic [7:0]        ct_t[4]   = '{8'h03, 8'h03, 8'h01, 8'h01};
  int                np_t[4]   = '{7, 4, 4, 5};

  rfe_tx_encoder rfe_tx_encoder_i (
    .clock(clock), .sys_rst(sys_rst), .bus(bus), .rd_data(rd_data),
    .rx_envelope(rxl[1]), .rx_active(rxl[2]), .rx_bit(rxl[3]),
    .generic_secure_if_signal(rxl[0]), .tx_envelope(env),
    .tx_active(act), .tx_fifo_ready(fifo_rdy),
    .test_signal_pin_out(pin_out), .test_signal_pin_oe(pin_oe),
    .io_fast_switching(io_fast));
  rfe_card_model rfe_card_model_i (
    .clock(clock), .tx_envelope(env), .tx_active(act), .resp(resp),
    .rx_lines(rxl), .pulses(pulses), .first_at(first_at));

  initial
  begin
    forever #5 clock = ~clock;
  end

  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus <= '0;
    @(posedge clock);
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    #1 chk("rd_data", rd_data, exp);
    @(posedge clock);
  endtask

  task automatic frame(logic [7:0] fr, logic [7:0] cd, logic [7:0] dat,
                       logic [7:0] ctl);
    wr(rfe_pkg::ADDR_FRAMING, fr);
    wr(rfe_pkg::ADDR_CODING, cd);
    wr(rfe_pkg::ADDR_TX_DATA, dat);
    wr(rfe_pkg::ADDR_TX_CTRL, ctl);
    repeat (4) @(posedge clock);
    while (act)
      @(posedge clock);
    repeat (2) @(posedge clock);
  endtask

  task automatic tally_and_finish();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // whole run needs about 35k cycles
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rd(8'h47, 8'h00);
    rd(8'h4C, 8'h02);
    wr(8'h47, 8'hFF);
    rd(8'h47, 8'h8F);
    wr(8'h48, 8'hFF);
    rd(8'h48, 8'hAB);
    wr(8'h4A, 8'h5A);
    rd(8'h4A, 8'h5A);
    rd(8'h60, 8'h00);
    // every pin source with both answer levels
    for (int r = 0; r < 2; r++)
      for (int s = 0; s < 10; s++)
      begin
        // alternating lane levels catch swapped sources
        resp <= r[0] ? 4'hA : 4'h5;
        wr(rfe_pkg::ADDR_TEST_OUT, {r[0], 3'h0, s[3:0]});
        repeat (4) @(posedge clock);
        chk("pin_oe", pin_oe, s > 1);
        chk("pin_out", pin_out & pin_oe,
            s == 3 || (s > 5 && (s + r) % 2 == 0));
        chk("io_fast", io_fast, r[0]);
      end
    // return-to-zero counts each one bit of the frame
    foreach (fr_t[i])
    begin
      frame(fr_t[i], 8'h47, 8'h0F, ct_t[i]);
      chk("pulses", pulses, np_t[i]);
    end
    frame(8'h00, 8'h47, 8'h01, 8'h01);
    d0 = first_at;
    frame(8'h80, 8'h47, 8'h01, 8'h01);
    chk("msb_delay", first_at - d0, 7 * 117);
    frame(8'h80, 8'h46, 8'h01, 8'h01);
    chk("rate_delay", first_at - d0, 7 * 233);
    for (int k = 5; k < 8; k++)
    begin
      frame(8'h00, {k[3:0], 4'h7}, 8'h01, 8'h01);
      chk("rz_delay", first_at - d0, 29 * (k - 4));
    end
    frame(8'h00, 8'hC7, 8'h01, 8'h01);
    chk("interval_delay", first_at - d0, 7 * 29);
    frame(8'h00, 8'hC7, 8'h00, 8'h01);
    chk("interval_delay", first_at - d0, 3 * 29);
    frame(8'h00, 8'h87, 8'h00, 8'h01);
    d0 = first_at;
    frame(8'h00, 8'h87, 8'h03, 8'h01);
    chk("slot_delay", first_at - d0, 3 * 116);
    // fill past full, extra write is dropped
    for (int i = 0; i < 17; i++)
      wr(rfe_pkg::ADDR_TX_DATA, 8'h55);
    rd(8'h4C, 8'h04);
    chk("fifo_ready", fifo_rdy, 1'b0);
    frame(8'h00, 8'h07, 8'h55, 8'h01);
    rd(8'h4C, 8'h02);
    tally_and_finish();
  end
endmodule
`default_nettype wire
